/* File: rtl/dame_regs.vh */
// constants for the data-area move engine: operation codes and control-word fields
// assumes a 16-bit word-addressed data area
`ifndef DAME_REGS_VH
`define DAME_REGS_VH

// operation codes on op_code
`define DAME_OP_DIGIT     2'h0
`define DAME_OP_BITS      2'h1
`define DAME_OP_BLOCK     2'h2
`define DAME_OP_FILL      2'h3

// digit move control word: three 4-bit fields
`define DAME_DG_SRC_LSB   0
`define DAME_DG_CNT_LSB   4
`define DAME_DG_DST_LSB   8
`define DAME_DG_MAX       4'h3

// bit-field transfer control word
`define DAME_BF_SBIT_LSB  0
`define DAME_BF_DBIT_LSB  4
`define DAME_BF_CNT_LSB   8
`define DAME_BF_CNT_W     8

// bit strides of the pointer counters
`define DAME_STRIDE_BIT   5'h01
`define DAME_STRIDE_WORD  5'h10

`endif

/* File: rtl/dame_mem.v */
// word-addressed data area: one write port and one read port
// read data come out of a register one clock after the address
`default_nettype none

module dame_mem #(
   parameter AW = 12,
   parameter DW = 16
) (
   input  wire          clk,
   input  wire          we,
   input  wire [AW-1:0] waddr,
   input  wire [DW-1:0] wdata,
   input  wire [AW-1:0] raddr,
   output reg  [DW-1:0] rdata_q
);

   reg [DW-1:0] mem [0:(1<<AW)-1];

   // read returns the old word when read and write hit the same address
   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata_q <= mem[raddr];
   end

endmodule // dame_mem

`default_nettype wire

/* File: rtl/dame_digit.v */
// digit move datapath: combinational merge of source digits into a destination word
// control word fields as in dame_regs.vh; range checking is done by the caller
`include "dame_regs.vh"
`default_nettype none

module dame_digit (
   input  wire [15:0] src_word,
   input  wire [15:0] dst_word,
   input  wire [15:0] ctrl,
   output reg  [15:0] result
);

   reg     [1:0] sd;
   reg     [1:0] dd;
   reg     [1:0] cnt;
   integer       k;

   always @* begin
      sd     = 2'h0;
      dd     = 2'h0;
      cnt    = ctrl[`DAME_DG_CNT_LSB+1:`DAME_DG_CNT_LSB];
      result = dst_word;
      for (k = 0; k < 4; k = k + 1) begin
         if (k[1:0] <= cnt) begin
            sd = ctrl[`DAME_DG_SRC_LSB+1:`DAME_DG_SRC_LSB] + k[1:0];
            dd = ctrl[`DAME_DG_DST_LSB+1:`DAME_DG_DST_LSB] + k[1:0];
            result[dd*4 +: 4] = src_word[sd*4 +: 4];
         end
      end
   end

endmodule // dame_digit

`default_nettype wire

/* File: rtl/dame_engine.v */
// data-area move engine: digit move, bit-field transfer, block transfer, block fill
// operations come from a sequencer on the same clock; the host port writes the
// data area only while the engine is idle; interrupt requests are on this clock too
//
// How it works
// - digit index wraps from top to bottom digit
// - digit fields above three raise the fault flag
// - bit-field copies up to 255 bits
// - zero bit count writes nothing
// - untouched destination bits keep their value
// - overlapping bit ranges copy correctly
// - block transfer copies words in order
// - full 16-bit word count, zero moves nothing
// - overlap picks direction reading before overwriting
// - interrupt waits until block transfer ends
// - fill writes source into start through end
// - fill start above end raises fault
// - interrupt waits until fill ends
`include "dame_regs.vh"
`default_nettype none

module dame_engine #(
   parameter AW = 12
) (
   input  wire          clk,
   input  wire          rst_n,
   // operation request
   input  wire          op_start,
   input  wire [1:0]    op_code,
   input  wire [AW-1:0] op_src,
   input  wire [AW-1:0] op_dst,
   input  wire [15:0]   op_arg,
   output wire          op_ready,
   output reg           op_done_q,
   output reg           operation_fault_flag,
   // interrupt deferral
   input  wire          irq_req,
   output wire          irq_start,
   // host access to the data area
   input  wire          ext_we,
   input  wire [AW-1:0] ext_addr,
   input  wire [15:0]   ext_wdata,
   output wire [15:0]   ext_rdata
);

   localparam BW = AW + 4;

   // each word, or each bit of a bit-field transfer, costs three cycles: read source, read destination, write
   localparam ST_IDLE = 3'h0;
   localparam ST_RSRC = 3'h1;
   localparam ST_RDST = 3'h2;
   localparam ST_WR   = 3'h3;
   localparam ST_DONE = 3'h4;

   reg  [2:0]    state_q;
   reg  [1:0]    op_q;
   reg  [15:0]   ctrl_q;
   reg  [BW-1:0] s_q;
   reg  [BW-1:0] d_q;
   reg  [16:0]   rem_q;
   reg           dec_q;
   reg  [15:0]   sword_q;
   reg           pend_q;

   wire [15:0]   rdata;
   wire [15:0]   digit_word;
   reg  [15:0]   wdata;
   wire          accept;
   wire          mem_we;
   wire [AW-1:0] raddr;
   wire [AW-1:0] waddr;
   wire [BW-1:0] stride;

   // start-time decode results
   reg           st_fault;
   reg           st_empty;
   reg  [BW-1:0] st_s;
   reg  [BW-1:0] st_d;
   reg  [16:0]   st_rem;
   reg           st_dec;
   reg  [BW-1:0] sb;
   reg  [BW-1:0] db;
   reg  [BW-1:0] nm1;
   reg  [AW-1:0] wn;

   function [15:0] put_bit;
      input [15:0] word;
      input [3:0]  pos;
      input        val;
      begin
         put_bit      = word;
         put_bit[pos] = val;
      end
   endfunction

   function [BW-1:0] word_ptr;
      input [AW-1:0] w;
      begin
         word_ptr = {w, 4'h0};
      end
   endfunction

   // one pointer step; the direction is fixed at accept so overlaps stay safe
   function [BW-1:0] step_ptr;
      input [BW-1:0] ptr;
      input [BW-1:0] step;
      input          down;
      begin
         step_ptr = down ? ptr - step : ptr + step;
      end
   endfunction

   // a digit field outside 0..3 names no digit of a word
   function digit_bad;
      input [3:0] field;
      begin
         digit_bad = (field > `DAME_DG_MAX);
      end
   endfunction

   assign accept   = op_start && (state_q == ST_IDLE);
   assign op_ready = (state_q == ST_IDLE);
   // pointers count bits: word address above, bit index in the low four bits
   assign stride   = {{(BW-5){1'b0}}, (op_q == `DAME_OP_BITS) ? `DAME_STRIDE_BIT : `DAME_STRIDE_WORD};

   // the host port writes the data area only while idle and reads it in every state but ST_RSRC and ST_RDST
   assign raddr     = (state_q == ST_RSRC) ? s_q[BW-1:4] :
                      (state_q == ST_RDST) ? d_q[BW-1:4] : ext_addr;
   assign waddr     = (state_q == ST_WR) ? d_q[BW-1:4] : ext_addr;
   // host writes while busy are dropped, not queued
   assign mem_we    = (state_q == ST_WR) || ((state_q == ST_IDLE) && ext_we);
   assign ext_rdata = rdata;

   always @* begin
      st_fault = 1'b0;
      st_empty = 1'b0;
      st_dec   = 1'b0;
      st_rem   = 17'h00001;
      sb       = word_ptr(op_src);
      db       = word_ptr(op_dst);
      st_s     = sb;
      st_d     = db;
      nm1      = {BW{1'b0}};
      wn       = {AW{1'b0}};
      case (op_code)
         `DAME_OP_DIGIT: begin
            st_fault = digit_bad(op_arg[`DAME_DG_SRC_LSB+3:`DAME_DG_SRC_LSB]) ||
                       digit_bad(op_arg[`DAME_DG_CNT_LSB+3:`DAME_DG_CNT_LSB]) ||
                       digit_bad(op_arg[`DAME_DG_DST_LSB+3:`DAME_DG_DST_LSB]);
            // a fault goes straight to DONE, so nothing is written
            st_empty = st_fault;
         end
         `DAME_OP_BITS: begin
            sb       = word_ptr(op_src) + {{(BW-4){1'b0}}, op_arg[`DAME_BF_SBIT_LSB+3:`DAME_BF_SBIT_LSB]};
            db       = word_ptr(op_dst) + {{(BW-4){1'b0}}, op_arg[`DAME_BF_DBIT_LSB+3:`DAME_BF_DBIT_LSB]};
            nm1      = {{(BW-8){1'b0}}, op_arg[`DAME_BF_CNT_LSB+7:`DAME_BF_CNT_LSB] - 8'h01};
            st_rem   = {9'h000, op_arg[`DAME_BF_CNT_LSB+7:`DAME_BF_CNT_LSB]};
            st_empty = (op_arg[`DAME_BF_CNT_LSB+7:`DAME_BF_CNT_LSB] == 8'h00);
            // copy downward when destination lies above
            // both words are reread for every bit, so packing across words holds
            st_dec   = (db > sb);
            st_s     = st_dec ? sb + nm1 : sb;
            st_d     = st_dec ? db + nm1 : db;
         end
         `DAME_OP_BLOCK: begin
            // full 16-bit count
            // counts beyond the data area wrap; staying inside is the issuer's duty
            st_rem   = {1'b0, op_arg};
            st_empty = (op_arg == 16'h0000);
            wn       = op_arg[AW-1:0] - {{(AW-1){1'b0}}, 1'b1};
            // descend when destination lies above source
            st_dec   = (op_dst > op_src);
            st_s     = st_dec ? word_ptr(op_src + wn) : sb;
            st_d     = st_dec ? word_ptr(op_dst + wn) : db;
         end
         default: begin
            // start above end is a fault
            st_fault = (op_dst > op_arg[AW-1:0]);
            st_empty = st_fault;
            // the single source word is reread on every pass
            st_rem   = {{(17-AW){1'b0}}, op_arg[AW-1:0] - op_dst} + 17'h00001;
         end
      endcase
   end

   // write data: engine result while writing, host data otherwise
   always @* begin
      case (op_q)
         `DAME_OP_DIGIT: wdata = digit_word;
         `DAME_OP_BITS:  wdata = put_bit(rdata, d_q[3:0], sword_q[s_q[3:0]]);
         default:        wdata = sword_q;
      endcase
      if (state_q != ST_WR) begin
         wdata = ext_wdata;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         // memory contents are kept through reset
         state_q              <= ST_IDLE;
         op_q                 <= 2'h0;
         ctrl_q               <= 16'h0000;
         s_q                  <= {BW{1'b0}};
         d_q                  <= {BW{1'b0}};
         rem_q                <= 17'h00000;
         dec_q                <= 1'b0;
         sword_q              <= 16'h0000;
         op_done_q            <= 1'b0;
         operation_fault_flag <= 1'b0;
      end else begin
         op_done_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (accept) begin
                  op_q   <= op_code;
                  ctrl_q <= op_arg;
                  s_q    <= st_s;
                  d_q    <= st_d;
                  rem_q  <= st_rem;
                  dec_q  <= st_dec;
                  operation_fault_flag <= st_fault;
                  state_q <= st_empty ? ST_DONE : ST_RSRC;
               end
            end
            ST_RSRC: begin
               state_q <= ST_RDST;
            end
            ST_RDST: begin
               // source word held while the destination read completes
               sword_q <= rdata;
               state_q <= ST_WR;
            end
            ST_WR: begin
               // step through the range in order
               // last word: leave through DONE so op_done_q trails the final write
               if (rem_q == 17'h00001) begin
                  state_q <= ST_DONE;
               end else begin
                  rem_q   <= rem_q - 17'h00001;
                  // fill keeps the one source word
                  if (op_q != `DAME_OP_FILL) begin
                     s_q <= step_ptr(s_q, stride, dec_q);
                  end
                  d_q     <= step_ptr(d_q, stride, dec_q);
                  state_q <= ST_RSRC;
               end
            end
            ST_DONE: begin
               op_done_q <= 1'b1;
               state_q   <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // requests wait while an operation runs
   // released only once the engine is idle
   assign irq_start = pend_q && (state_q == ST_IDLE);

   // a new request in the grant cycle stays pending
   always @(posedge clk) begin
      if (!rst_n) begin
         pend_q <= 1'b0;
      end else if (irq_req) begin
         pend_q <= 1'b1;
      end else if (irq_start) begin
         pend_q <= 1'b0;
      end
   end

   dame_digit u_digit (
      .src_word (sword_q),
      .dst_word (rdata),
      .ctrl     (ctrl_q),
      .result   (digit_word)
   );

   dame_mem #(
      .AW (AW),
      .DW (16)
   ) u_mem (
      .clk     (clk),
      .we      (mem_we),
      .waddr   (waddr),
      .wdata   (wdata),
      .raddr   (raddr),
      .rdata_q (rdata)
   );

endmodule // dame_engine

`default_nettype wire

/* File: test/dame_engine_props.sv */
// checker for the data-area move engine: fault flag and completion timing
// assumes synchronous active-low reset and op codes from dame_regs.vh
`include "dame_regs.vh"
`default_nettype none
module dame_engine_props #(
   parameter AW = 12
) (
   input wire logic          clk,
   input wire logic          rst_n,
   input wire logic          op_start,
   input wire logic [1:0]    op_code,
   input wire logic [AW-1:0] op_dst,
   input wire logic [15:0]   op_arg,
   input wire logic          op_ready,
   input wire logic          op_done_q,
   input wire logic          operation_fault_flag,
   input wire logic          irq_req,
   input wire logic          irq_start
);
   wire acc = op_start && op_ready;
   wire flt = operation_fault_flag;
   wire dig = acc && op_code == `DAME_OP_DIGIT;
   wire bad = op_arg[3:0] > 4'h3 || op_arg[7:4] > 4'h3 || op_arg[11:8] > 4'h3;
   wire fil = acc && op_code == `DAME_OP_FILL;
   wire late = op_dst > op_arg[AW-1:0];
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_digit_fault: assert property (dig && bad |=> flt ##1 op_done_q) else $error("digit fault");
   a_digit_time: assert property (dig && !bad |=> !flt ##4 op_done_q) else $error("digit timing");
   a_bits_empty: assert property (acc && op_code == `DAME_OP_BITS && op_arg[15:8] == 8'h00
      |=> !flt ##1 op_done_q) else $error("empty bit move");
   a_block_empty: assert property (acc && op_code == `DAME_OP_BLOCK && op_arg == 16'h0000
      |=> !flt ##1 op_done_q) else $error("empty block");
   a_block_word_transfer_clear: assert property (acc && op_code[1] != op_code[0] |=> !flt) else $error("fault set");
   a_fill_fault: assert property (fil && late |=> flt ##1 op_done_q) else $error("fill fault");
   a_fill_clear: assert property (fil && !late |=> !flt ##3 !op_done_q) else $error("fill early");
   a_fill_single: assert property (fil && op_dst == op_arg[AW-1:0]
      |=> !flt ##4 op_done_q) else $error("single fill timing");
   a_irq_busy: assert property (!op_ready |-> !irq_start) else $error("irq while busy");
   a_irq_clear: assert property (irq_start && !irq_req |=> !irq_start) else $error("irq held");
   a_irq_kept: assert property (irq_req |=> irq_start || !op_ready) else $error("irq lost");
   a_accept_busy: assert property (acc |=> !op_ready) else $error("still idle");
endmodule // dame_engine_props

bind dame_engine dame_engine_props #(.AW(AW)) dame_engine_props_i (
   .clk(clk), .rst_n(rst_n), .op_start(op_start), .op_code(op_code), .op_dst(op_dst),
   .op_arg(op_arg), .op_ready(op_ready), .op_done_q(op_done_q),
   .operation_fault_flag(operation_fault_flag), .irq_req(irq_req), .irq_start(irq_start));
`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench for the data-area move engine: digit, bit-field, block, fill
// assumes the host port reaches the data area while the engine is idle
`include "dame_regs.vh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        op_start = 1'b0;
   logic [1:0]  op_code = 2'h0;
   logic [11:0] op_src = 12'h000;
   logic [11:0] op_dst = 12'h000;
   logic [15:0] op_arg = 16'h0000;
   logic        irq_req = 1'b0;
   logic        ext_we = 1'b0;
   logic [11:0] ext_addr = 12'h000;
   logic [15:0] ext_wdata = 16'h0000;
   wire         op_ready;
   wire         op_done_q;
   wire         operation_fault_flag;
   wire         irq_start;
   wire  [15:0] ext_rdata;
   int          err_count = 0;
   int          cmp_count = 0;
   logic [31:0] w;
   logic [31:0] m;
   always #20 clk = ~clk;
   dame_engine #(.AW(12)) dame_engine_i (
      .clk(clk), .rst_n(rst_n), .op_start(op_start), .op_code(op_code), .op_src(op_src),
      .op_dst(op_dst), .op_arg(op_arg), .op_ready(op_ready), .op_done_q(op_done_q),
      .operation_fault_flag(operation_fault_flag), .irq_req(irq_req), .irq_start(irq_start),
      .ext_we(ext_we), .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata));
   task automatic complete_run();
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(negedge clk);
      ext_we = 1'b1;
      ext_addr = a;
      ext_wdata = d;
      @(negedge clk);
      ext_we = 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [15:0] e);
      @(negedge clk);
      ext_addr = a;
      @(negedge clk);
      chk(ext_rdata, e);
   endtask
   // operation with an optional interrupt pulse just after the accept edge
   task automatic run(input logic [1:0] c, input logic [11:0] s, input logic [11:0] d,
                      input logic [15:0] a, input logic f, input logic irq);
      int n;
      @(negedge clk);
      op_code = c;
      op_src = s;
      op_dst = d;
      op_arg = a;
      op_start = 1'b1;
      @(negedge clk);
      op_start = 1'b0;
      irq_req = irq;
      @(negedge clk);
      irq_req = 1'b0;
      n = 0;
      while (op_done_q !== 1'b1 && n < 1000) begin
         chk({15'h0, irq_start}, 16'h0000);
         @(negedge clk);
         n++;
      end
      chk({15'h0, op_done_q}, 16'h0001);
      chk({15'h0, operation_fault_flag}, {15'h0, f});
      if (irq) chk({15'h0, irq_start}, 16'h0001);
   endtask
   task automatic t_digit();
      wr(12'h010, 16'h4321);
      wr(12'h011, 16'h0000);
      wr(12'h012, 16'haaaa);
      run(`DAME_OP_DIGIT, 12'h010, 12'h011, 16'h0031, 1'b0, 1'b0);
      rd(12'h011, 16'h1432);
      run(`DAME_OP_DIGIT, 12'h010, 12'h012, 16'h0313, 1'b0, 1'b0);
      rd(12'h012, 16'h4aa1);
      for (int i = 0; i < 3; i++) run(`DAME_OP_DIGIT, 12'h010, 12'h012, 16'h0004 << (4 * i), 1'b1, 1'b0);
      rd(12'h012, 16'h4aa1);
      // a good move after faults clears the flag again
      run(`DAME_OP_DIGIT, 12'h010, 12'h012, 16'h0002, 1'b0, 1'b0);
      rd(12'h012, 16'h4aa3);
      $display("test digit done");
   endtask
   task automatic t_bits();
      wr(12'h020, 16'hf0f0);
      wr(12'h021, 16'h1234);
      wr(12'h030, 16'h5555);
      wr(12'h031, 16'h5555);
      m = 32'h000f_ffff << 4;
      w = (32'h5555_5555 & ~m) | (((32'h1234_f0f0 >> 6) << 4) & m);
      // raise the fault first so the transfer has something to clear
      run(`DAME_OP_FILL, 12'h060, 12'h001, 16'h0000, 1'b1, 1'b0);
      run(`DAME_OP_BITS, 12'h020, 12'h030, 16'h1446, 1'b0, 1'b0);
      rd(12'h030, w[15:0]);
      rd(12'h031, w[31:16]);
      wr(12'h040, 16'h1234);
      wr(12'h041, 16'h5678);
      run(`DAME_OP_BITS, 12'h040, 12'h040, 16'h1840, 1'b0, 1'b0);
      rd(12'h040, 16'h2344);
      rd(12'h041, 16'h5781);
      run(`DAME_OP_BITS, 12'h020, 12'h030, 16'h0046, 1'b0, 1'b0);
      rd(12'h030, w[15:0]);
      $display("test bits done");
   endtask
   task automatic t_block();
      for (int i = 0; i < 4; i++) wr(12'h050 + 12'(i), 16'h1000 + 16'(i));
      run(`DAME_OP_DIGIT, 12'h010, 12'h012, 16'h0f00, 1'b1, 1'b0);
      // every range below stays inside the data area
      run(`DAME_OP_BLOCK, 12'h050, 12'h052, 16'h0004, 1'b0, 1'b1);
      for (int i = 0; i < 4; i++) rd(12'h052 + 12'(i), 16'h1000 + 16'(i));
      run(`DAME_OP_BLOCK, 12'h052, 12'h051, 16'h0003, 1'b0, 1'b0);
      for (int i = 0; i < 3; i++) rd(12'h051 + 12'(i), 16'h1000 + 16'(i));
      run(`DAME_OP_BLOCK, 12'h051, 12'h054, 16'h0000, 1'b0, 1'b0);
      rd(12'h054, 16'h1002);
      $display("test block done");
   endtask
   task automatic t_fill();
      wr(12'h060, 16'hbeef);
      for (int i = 0; i < 6; i++) wr(12'h070 + 12'(i), 16'h0000);
      run(`DAME_OP_FILL, 12'h060, 12'h070, 16'h0073, 1'b0, 1'b1);
      for (int i = 0; i < 4; i++) rd(12'h070 + 12'(i), 16'hbeef);
      rd(12'h074, 16'h0000);
      run(`DAME_OP_FILL, 12'h060, 12'h075, 16'h0074, 1'b1, 1'b0);
      rd(12'h075, 16'h0000);
      run(`DAME_OP_FILL, 12'h060, 12'h075, 16'h0075, 1'b0, 1'b0);
      rd(12'h075, 16'hbeef);
      $display("test fill done");
   endtask
   // mid-run reset: engine idles, pending request drops; the accept has already cleared the fault
   task automatic t_reset();
      run(`DAME_OP_FILL, 12'h060, 12'h081, 16'h0080, 1'b1, 1'b0);
      @(negedge clk);
      op_code = `DAME_OP_FILL;
      op_src = 12'h060;
      op_dst = 12'h080;
      op_arg = 16'h0088;
      op_start = 1'b1;
      @(negedge clk);
      op_start = 1'b0;
      irq_req = 1'b1;
      chk({15'h0, op_ready}, 16'h0000);
      @(negedge clk);
      irq_req = 1'b0;
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      chk({14'h0, op_ready, op_done_q}, 16'h0002);
      chk({14'h0, operation_fault_flag, irq_start}, 16'h0000);
      $display("test reset done");
   endtask
   initial begin
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      t_digit();
      t_bits();
      t_block();
      t_fill();
      t_reset();
      complete_run();
   end
   // the whole run needs a few hundred cycles, so this leaves ample margin
   initial begin
      #400us;
      err_count++;
      $display("unexpected at %0t: watchdog expired", $time);
      complete_run();
   end
endmodule // testbench
`default_nettype wire
